// ===== boot_seq_pkg.sv
package boot_seq_pkg;
  // Timing figures, and cycle counts at the 200 MHz system clock
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned RESTART_MS = 3;
  localparam int unsigned PROG_WIN_MS = 100;
  localparam int unsigned FAIL_WIN_S = 60;
  localparam longint unsigned RESTART_CYC =
    longint'(CLK_HZ) / 1000 * RESTART_MS;
  localparam longint unsigned PROG_WIN_CYC =
    longint'(CLK_HZ) / 1000 * PROG_WIN_MS;
  localparam longint unsigned FAIL_WIN_CYC = longint'(CLK_HZ) * FAIL_WIN_S;
  // Largest accepted boot image, in bytes
  localparam int unsigned MAX_IMAGE_BYTES = 512 * 1024;
  // Pins borrowed for boot: top six of 64
  localparam int unsigned BOOT_PIN_LO = 58;
  localparam int unsigned STRAP_LO = 59;
  localparam int unsigned SER_RX_PIN = 63;
  localparam int unsigned SER_TX_PIN = 62;
  localparam int unsigned TIMER_W = 36;
  // Strap selection pattern on the three strap pins
  localparam logic [2:0] STRAP_SERIAL_ONLY = 3'h0;

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_RESET   = 8'h01,
    ST_WAIT    = 8'h02,
    ST_PROGWIN = 8'h04,
    ST_FLASH   = 8'h08,
    ST_CARD    = 8'h10,
    ST_FAILWIN = 8'h20,
    ST_RUN     = 8'h40,
    ST_OFF     = 8'h80
  } seq_state_e;

  // Result from the loader engine, link clock domain
  typedef struct packed {
    logic done;
    logic fail;
    logic too_big;
  } load_result_s;
endpackage

// ===== boot_source_sequencer.sv
`timescale 1ns/1ps
// Operation
// - While chip reset is low all cores stay stopped and all I/O pins float.
// - After reset rises the device waits 3 ms before starting up.
// - Flash boot opens a 100 ms serial window, then boots from flash.
// - Failed flash boot opens a 60 s serial window, then shuts down.
// - Card boot starts at once with no serial window.
// - Failed card boot opens a 60 s serial window, then shuts down.
// - Card boot tries the primary file, the alternate only if it is absent.
// - Boot images up to 512 KB are accepted and larger ones fail.
// - A closed selection switch chooses flash, an open one the card.
// - The top six pins serve boot only during start-up, then are released.
// - A three-pin strap pattern picks serial only or flash/card boot.
// - Serial windows talk to the host over the two top pins.
// - The host link uses 8 data bits, 1 stop bit and no parity.
module boot_source_sequencer #(
  parameter longint unsigned RESTART_CYC = boot_seq_pkg::RESTART_CYC,
  parameter longint unsigned PROG_WIN_CYC = boot_seq_pkg::PROG_WIN_CYC,
  parameter longint unsigned FAIL_WIN_CYC = boot_seq_pkg::FAIL_WIN_CYC
) (
  input wire logic REF_CLK_I, // System clock, 200 MHz
  input wire logic RSTN_I, // Chip reset, active low, async
  input wire logic LINK_CLK_I, // Loader engine clock
  input wire logic [2:0] STRAP_I, // Boot strap pins
  input wire logic FLASH_SEL_I, // Switch ties flash select to strap pin
  input wire logic FILE_PRIMARY_I, // Loader: primary boot file found
  input wire logic FILE_ALT_I, // Loader: alternate boot file found
  input wire logic [19:0] IMAGE_BYTES_I, // Loader: image size in bytes
  input wire logic LOAD_OK_I, // Loader: image read, level
  input wire logic LOAD_ERR_I, // Loader: media error, level
  input wire logic HOST_LOADED_I, // Serial loader: image received
  output logic CORES_RUN_O, // Cores released to run
  output logic BOOT_PINS_OWN_O, // Boot logic owns top six pins
  output logic SER_EN_O, // Serial window open on top two pins
  output logic FLASH_BOOT_O, // Flash load request
  output logic CARD_BOOT_O, // Card load request
  output logic USE_ALT_FILE_O, // Card: use alternate file name
  output logic SHUTDOWN_O, // Device shut down
  output logic [5:0] PIN_OE_O // Enables for the top six pins
);
  localparam int unsigned TW = boot_seq_pkg::TIMER_W;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: loader verdict registered on the link clock
  boot_seq_pkg::load_result_s l_res_r;
  boot_seq_pkg::load_result_s l_res_nxt;
  boot_seq_pkg::load_result_s s_res_sync1_r;
  boot_seq_pkg::load_result_s s_res_sync2_r;

  // Verdict bits are levels that change once per boot, and the loader
  // settles the size before its verdict, so a two-flop sync per bit is
  // safe; an image of exactly the limit is still accepted
  always_comb begin
    l_res_nxt.done = LOAD_OK_I && !LOAD_ERR_I;
    l_res_nxt.fail = LOAD_ERR_I;
    l_res_nxt.too_big =
      (IMAGE_BYTES_I > 20'(boot_seq_pkg::MAX_IMAGE_BYTES));
  end

  always_ff @(posedge LINK_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      l_res_r <= '0;
    end else begin
      l_res_r <= l_res_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system clock domain
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
      s_res_sync1_r <= 3'h0;
      s_res_sync2_r <= 3'h0;
    end else begin
      sync1_r <= {STRAP_I, FLASH_SEL_I, FILE_PRIMARY_I, FILE_ALT_I,
                  HOST_LOADED_I};
      sync2_r <= sync1_r;
      s_res_sync1_r <= l_res_r;
      s_res_sync2_r <= s_res_sync1_r;
    end
  end

  logic [2:0] strap_s;
  logic flash_sel_s;
  logic prim_s;
  logic alt_s;
  logic host_s;
  logic ok_s;
  logic bad_s;
  assign strap_s = sync2_r[6:4];
  assign flash_sel_s = sync2_r[3];
  assign prim_s = sync2_r[2];
  assign alt_s = sync2_r[1];
  assign host_s = sync2_r[0];
  assign ok_s = s_res_sync2_r.done && !s_res_sync2_r.too_big;
  assign bad_s = s_res_sync2_r.fail || s_res_sync2_r.too_big;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  boot_seq_pkg::seq_state_e st_r;
  boot_seq_pkg::seq_state_e st_nxt;
  logic [TW-1:0] tmr_r;
  logic [TW-1:0] tmr_nxt;
  logic alt_r;
  logic alt_nxt;

  // Timer counts up inside each timed state and clears on every entry into ST_WAIT, ST_PROGWIN or ST_FAILWIN
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r + TW'(1);
    alt_nxt = alt_r;
    case (st_r)
      boot_seq_pkg::ST_RESET: begin
        st_nxt = boot_seq_pkg::ST_WAIT;
        tmr_nxt = '0;
      end
      boot_seq_pkg::ST_WAIT: begin
        if (tmr_r >= TW'(RESTART_CYC - 1)) begin
          tmr_nxt = '0;
          if (strap_s == boot_seq_pkg::STRAP_SERIAL_ONLY)
            st_nxt = boot_seq_pkg::ST_FAILWIN;
          else if (flash_sel_s)
            st_nxt = boot_seq_pkg::ST_PROGWIN;
          else
            st_nxt = boot_seq_pkg::ST_CARD;
        end
      end
      boot_seq_pkg::ST_PROGWIN: begin
        if (host_s) begin
          st_nxt = boot_seq_pkg::ST_RUN;
        end else if (tmr_r >= TW'(PROG_WIN_CYC - 1)) begin
          st_nxt = boot_seq_pkg::ST_FLASH;
          tmr_nxt = '0;
        end
      end
      boot_seq_pkg::ST_FLASH: begin
        tmr_nxt = '0;
        if (ok_s)
          st_nxt = boot_seq_pkg::ST_RUN;
        else if (bad_s)
          st_nxt = boot_seq_pkg::ST_FAILWIN;
      end
      boot_seq_pkg::ST_CARD: begin
        tmr_nxt = '0;
        if (!prim_s && alt_s)
          alt_nxt = 1'b1;
        if (ok_s)
          st_nxt = boot_seq_pkg::ST_RUN;
        else if (bad_s)
          st_nxt = boot_seq_pkg::ST_FAILWIN;
      end
      boot_seq_pkg::ST_FAILWIN: begin
        if (host_s)
          st_nxt = boot_seq_pkg::ST_RUN;
        else if (tmr_r >= TW'(FAIL_WIN_CYC - 1))
          st_nxt = boot_seq_pkg::ST_OFF;
      end
      boot_seq_pkg::ST_RUN: tmr_nxt = '0;
      boot_seq_pkg::ST_OFF: tmr_nxt = '0;
      default: begin
        st_nxt = boot_seq_pkg::ST_RESET;
        tmr_nxt = '0;
      end
    endcase
  end

  // Reset returns to the start so every window is timed afresh
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_r <= boot_seq_pkg::ST_RESET;
      tmr_r <= '0;
      alt_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      alt_r <= alt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; all clear and pins float under reset
  logic win_nxt;
  logic own_nxt;
  always_comb begin
    win_nxt = (st_nxt == boot_seq_pkg::ST_PROGWIN) ||
              (st_nxt == boot_seq_pkg::ST_FAILWIN);
    own_nxt = !((st_nxt == boot_seq_pkg::ST_RUN) ||
                (st_nxt == boot_seq_pkg::ST_OFF) ||
                (st_nxt == boot_seq_pkg::ST_RESET));
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      CORES_RUN_O <= 1'b0;
      BOOT_PINS_OWN_O <= 1'b0;
      SER_EN_O <= 1'b0;
      FLASH_BOOT_O <= 1'b0;
      CARD_BOOT_O <= 1'b0;
      USE_ALT_FILE_O <= 1'b0;
      SHUTDOWN_O <= 1'b0;
      PIN_OE_O <= 6'h00;
    end else begin
      CORES_RUN_O <= (st_nxt == boot_seq_pkg::ST_RUN);
      BOOT_PINS_OWN_O <= own_nxt;
      SER_EN_O <= win_nxt;
      FLASH_BOOT_O <= (st_nxt == boot_seq_pkg::ST_FLASH);
      CARD_BOOT_O <= (st_nxt == boot_seq_pkg::ST_CARD);
      USE_ALT_FILE_O <= alt_nxt;
      SHUTDOWN_O <= (st_nxt == boot_seq_pkg::ST_OFF);
      // Only the transmit pin (bit 4 = pin 62) drives in a window; 8N1
      // framing itself is the serial loader's job
      PIN_OE_O <= {1'b0, win_nxt, 4'h0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_flash_fail;
    st_r == boot_seq_pkg::ST_FLASH ##1 st_r == boot_seq_pkg::ST_FAILWIN;
  endsequence

  AST_RESET_QUIET: assert property (
    @(posedge REF_CLK_I) !RSTN_I |=> (PIN_OE_O == 6'h00 && !CORES_RUN_O))
    else $error("Pins driven or cores run during reset");
  AST_WAIT_EXIT: assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    (st_r == boot_seq_pkg::ST_WAIT && tmr_r < TW'(RESTART_CYC - 1))
    |=> st_r == boot_seq_pkg::ST_WAIT)
    else $error("Left restart wait early");
  AST_CARD_DIRECT: assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    (st_r == boot_seq_pkg::ST_CARD) |-> !SER_EN_O)
    else $error("Serial window during card boot");
  AST_FLASH_FAIL: assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    s_flash_fail |-> SER_EN_O)
    else $error("No window after flash failure");
  AST_PROG_FIRST: assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    $rose(FLASH_BOOT_O) |-> $past(st_r) == boot_seq_pkg::ST_PROGWIN)
    else $error("Flash boot without programming window");
  AST_OFF_TIMED: assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    $rose(SHUTDOWN_O) |-> $past(tmr_r) >= TW'(FAIL_WIN_CYC - 1))
    else $error("Shutdown before window ended");
  AST_PINS_FREE: assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    CORES_RUN_O |-> !BOOT_PINS_OWN_O && PIN_OE_O == 6'h00)
    else $error("Boot pins held while running");
  AST_ALT_FILE: assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    $rose(USE_ALT_FILE_O) |-> !$past(prim_s))
    else $error("Alternate file used with primary present");
  // Only the transmit pin of the top two may drive in a window
  AST_WINDOW_PINS: assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    SER_EN_O |-> PIN_OE_O == 6'h10)
    else $error("Serial window without transmit pin enabled");
  // An oversized image must end in the failure window, never in a run
  AST_BIG_REFUSED: assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    (CARD_BOOT_O || FLASH_BOOT_O) && s_res_sync2_r.too_big
    |=> SER_EN_O && !CORES_RUN_O)
    else $error("Oversized image not refused");
endmodule

// ===== loader_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Flash or card loader on the link clock, answering slowly
module loader_model (
  input wire logic link_clk_i, // Link clock, runs only during a load
  input wire logic rstn_i, // Chip reset, active low
  input wire logic req_i, // Flash or card load request
  input wire logic fail_i, // Answer with a media error
  input wire logic prim_i, // Primary boot file present on card
  input wire logic big_i, // Offer an image one byte over the limit
  output logic prim_o, // Primary file found
  output logic alt_o, // Alternate file found
  output logic [19:0] bytes_o, // Image size in bytes
  output logic ok_o, // Image read
  output logic err_o // Media error
);
  logic [1:0] dly_r;
  // Alternate always present, so only the primary decides the name
  assign prim_o = prim_i;
  assign alt_o = 1'b1;
  // Image at the size limit exactly, the hardest legal case, or one
  // byte past it so that the refusal is seen too
  assign bytes_o = big_i ? 20'h80001 : 20'h80000;
  // Verdict on the fourth link clock, held as a level until reset
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dly_r <= 2'h0;
      ok_o <= 1'b0;
      err_o <= 1'b0;
    end else if (req_i && dly_r != 2'h3) begin
      dly_r <= dly_r + 2'h1;
    end else if (req_i) begin
      ok_o <= !fail_i;
      err_o <= fail_i;
    end
  end
endmodule

// ===== boot_source_sequencer_tb_top.sv
`timescale 1ns/1ps
module boot_source_sequencer_tb_top;
  localparam int RST = 20;
  localparam int PROG = 50;
  localparam int FAIL = 80;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  // Starts high so that the first restart gives a real falling edge
  logic rstn = 1'b1;
  logic big = 1'b0;
  logic [2:0] strap = 3'h1;
  logic fsel = 1'b1;
  logic fail = 1'b0;
  logic prim = 1'b1;
  logic host = 1'b0;
  logic prim_f, alt_f, ok, err, run, own, ser, fb, cb, alt, off;
  logic [19:0] nb;
  logic [5:0] oe;
  wire [4:0] outs = {off, run, cb, fb, ser};
  int n_fail = 0;
  int n_compared = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////////
  // Clocks; the link clock stands still outside a load
  initial forever #2.5 clk = ~clk;
  initial begin
    #1.3;
    forever begin
      #7.5;
      if (fb || cb || lclk) lclk = ~lclk;
    end
  end
  boot_source_sequencer #(.RESTART_CYC(RST), .PROG_WIN_CYC(PROG),
    .FAIL_WIN_CYC(FAIL)) uut (.REF_CLK_I(clk), .RSTN_I(rstn),
    .LINK_CLK_I(lclk), .STRAP_I(strap), .FLASH_SEL_I(fsel),
    .FILE_PRIMARY_I(prim_f), .FILE_ALT_I(alt_f), .IMAGE_BYTES_I(nb),
    .LOAD_OK_I(ok), .LOAD_ERR_I(err), .HOST_LOADED_I(host),
    .CORES_RUN_O(run), .BOOT_PINS_OWN_O(own), .SER_EN_O(ser),
    .FLASH_BOOT_O(fb), .CARD_BOOT_O(cb), .USE_ALT_FILE_O(alt),
    .SHUTDOWN_O(off), .PIN_OE_O(oe));
  loader_model loader (.link_clk_i(lclk), .rstn_i(rstn), .req_i(fb || cb),
    .fail_i(fail), .prim_i(prim), .big_i(big), .prim_o(prim_f),
    .alt_o(alt_f), .bytes_o(nb), .ok_o(ok), .err_o(err));
  ////////////////////////////////////////////////////////////////////////////
  // Shared checks and waits
  task automatic conclude;
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Cycle count of the last wait must fall in a window
  task automatic rng(input int lo, input int hi);
    chk(8'(n >= lo && n <= hi), 8'h01);
  endtask
  // Bounded wait for one output; running out ends the run
  task automatic wait_hi(input int k, input int lim);
    n = 0;
    while (outs[k] !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        n_fail++;
        conclude();
      end
    end
  endtask
  // Reset with a new strap setup; all outputs but alt checked quiet while held
  task automatic restart(input logic [2:0] s, input logic f, input logic e,
                         input logic p);
    @(negedge clk);
    rstn = 1'b0;
    strap = s;
    fsel = f;
    fail = e;
    prim = p;
    host = 1'b0;
    repeat (6) @(negedge clk);
    chk({run, own, ser, fb, cb, off, 2'h0}, 8'h00);
    chk({2'h0, oe}, 8'h00);
    rstn = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic flash_ok;
    restart(3'h2, 1'b1, 1'b0, 1'b1);
    wait_hi(0, RST + 8);
    repeat (10) @(negedge clk);
    restart(3'h2, 1'b1, 1'b0, 1'b1);
    wait_hi(0, RST + 8);
    rng(RST + 1, RST + 4);
    chk({own, 1'b0, oe}, 8'h90);
    wait_hi(1, PROG + 8);
    rng(PROG, PROG + 2);
    wait_hi(3, 16);
    chk({own, ser, oe}, 8'h00);
  endtask
  task automatic flash_fail;
    restart(3'h1, 1'b1, 1'b1, 1'b1);
    wait_hi(1, RST + PROG + 12);
    wait_hi(0, 16);
    chk({fb, run, oe}, 8'h10);
    wait_hi(4, FAIL + 8);
    rng(FAIL, FAIL + 2);
    chk({run, ser}, 8'h00);
  endtask
  task automatic card_fail;
    restart(3'h4, 1'b0, 1'b1, 1'b0);
    wait_hi(2, RST + 8);
    rng(RST + 1, RST + 4);
    chk(ser, 1'b0);
    wait_hi(0, 16);
    chk(alt, 1'b1);
    wait_hi(4, FAIL + 8);
    rng(FAIL, FAIL + 2);
  endtask
  task automatic card_ok;
    restart(3'h7, 1'b0, 1'b0, 1'b1);
    wait_hi(2, RST + 8);
    wait_hi(3, 16);
    chk({alt, ser, off}, 8'h00);
  endtask
  // Card image one byte over the limit must be refused
  task automatic image_big;
    big = 1'b1;
    restart(3'h4, 1'b0, 1'b0, 1'b1);
    wait_hi(2, RST + 8);
    wait_hi(0, 16);
    chk({run, cb, alt, off}, 8'h00);
    big = 1'b0;
  endtask
  task automatic serial_only;
    restart(3'h0, 1'b1, 1'b0, 1'b1);
    wait_hi(0, RST + 8);
    chk({fb, cb, 1'b0, oe}, 8'h10);
    host = 1'b1;
    wait_hi(3, 8);
    chk(off, 1'b0);
  endtask
  initial begin
    flash_ok();
    flash_fail();
    card_fail();
    card_ok();
    image_big();
    serial_only();
    conclude();
  end
endmodule
